// ==== dprh_port_ctrl.sv ====
// Host controller that drives one port of the asynchronous dual-port memory
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`default_nettype none

module dprh_port_ctrl #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // User request side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_byte_en,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic mailbox_pending,
  output logic contention_seen,
  // Memory port pins
  output logic chip_sel_n,
  output logic rd_wr_n,
  output logic out_gate_n,
  output logic token_latch_select_n,
  output logic high_byte_lane_sel_n,
  output logic low_byte_lane_sel_n,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic contention_n_in,
  input wire logic mailbox_n_in
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DATA_W != 16 && DATA_W != 8) begin : g_bad_width
    $error("DATA_W must be 8 or 16");
  end
  if (ADDR_W < dprh_pkg::TOKEN_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too small for token addressing");
  end
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] din_s1_reg, din_s2_reg;
  logic busy_s1_reg, busy_s2_reg, mail_s1_reg, mail_s2_reg;
  // Pin inputs are asynchronous to sys_clk; first stage feeds second only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
      mail_s1_reg <= 1'b0;
      mail_s2_reg <= 1'b0;
    end else begin
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      busy_s1_reg <= ~contention_n_in;
      busy_s2_reg <= busy_s1_reg;
      mail_s1_reg <= ~mailbox_n_in;
      mail_s2_reg <= mail_s1_reg;
    end
  end
  assign mailbox_pending = mail_s2_reg;
  assign contention_seen = busy_s2_reg;
  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  dprh_pkg::dprh_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [1:0] kind_reg, kind_next;
  logic cs_n_reg, cs_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic tok_n_reg, tok_n_next, ub_n_reg, ub_n_next, lb_n_reg, lb_n_next;
  logic doe_reg, doe_next, rsp_reg, rsp_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dout_reg, dout_next, rdata_reg, rdata_next;
  logic is_wr;
  assign is_wr = kind_reg[dprh_pkg::KIND_WR_BIT];
  // Next values of the sequencer and every pin
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    kind_next = kind_reg;
    cs_n_next = cs_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    tok_n_next = tok_n_reg;
    ub_n_next = ub_n_reg;
    lb_n_next = lb_n_reg;
    doe_next = doe_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    rdata_next = rdata_reg;
    rsp_next = 1'b0;
    case (state_reg)
      dprh_pkg::DPRH_IDLE: begin
        if (req_valid) begin
          kind_next = req_kind;
          addr_next = req_addr;
          dout_next = req_wdata;
          // token access uses its own select
          if (req_kind[dprh_pkg::KIND_TOKEN_BIT]) begin
            tok_n_next = 1'b0;
          end else begin
            cs_n_next = 1'b0;
          end
          // Byte lanes only exist on the wide part; idle lanes stay high
          if (DATA_W == 16 && !req_kind[dprh_pkg::KIND_TOKEN_BIT]) begin
            ub_n_next = ~req_byte_en[1];
            lb_n_next = ~req_byte_en[0];
          end
          // reads open the output gate with the select
          oe_n_next = req_kind[dprh_pkg::KIND_WR_BIT];
          doe_next = req_kind[dprh_pkg::KIND_WR_BIT];
          state_next = dprh_pkg::DPRH_SETUP;
        end
      end
      dprh_pkg::DPRH_SETUP: begin
        // data already driven a full cycle before the strobe
        if (is_wr) begin
          we_n_next = 1'b0;
          cnt_next = dprh_pkg::WRITE_CYC - 8'h01;
        end else begin
          cnt_next = dprh_pkg::READ_CYC - 8'h01;
        end
        state_next = dprh_pkg::DPRH_STROBE;
      end
      dprh_pkg::DPRH_STROBE: begin
        // Stretch writes under contention so arbitration settles first
        if (is_wr && busy_s2_reg) begin
          cnt_next = cnt_reg;
        end else if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else if (is_wr) begin
          // direction edge ends the write, data still held
          we_n_next = 1'b1;
          state_next = dprh_pkg::DPRH_HOLD;
        end else begin
          // sample only after access plus pass-through delay
          rdata_next = din_s2_reg;
          rsp_next = 1'b1;
          cs_n_next = 1'b1;
          tok_n_next = 1'b1;
          oe_n_next = 1'b1;
          ub_n_next = 1'b1;
          lb_n_next = 1'b1;
          cnt_next = dprh_pkg::RECOVER_CYC;
          state_next = dprh_pkg::DPRH_RECOVER;
        end
      end
      dprh_pkg::DPRH_HOLD: begin
        rsp_next = 1'b1;
        cs_n_next = 1'b1;
        tok_n_next = 1'b1;
        ub_n_next = 1'b1;
        lb_n_next = 1'b1;
        doe_next = 1'b0;
        cnt_next = dprh_pkg::RECOVER_CYC;
        state_next = dprh_pkg::DPRH_RECOVER;
      end
      dprh_pkg::DPRH_RECOVER: begin
        // selects stay off before any following token read
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          state_next = dprh_pkg::DPRH_IDLE;
        end
      end
      default: begin
        state_next = dprh_pkg::DPRH_IDLE;
      end
    endcase
  end
  // Register stage for sequencer and pins
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= dprh_pkg::DPRH_IDLE;
      cnt_reg <= 8'h00;
      kind_reg <= dprh_pkg::KIND_ARRAY_RD;
      cs_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      tok_n_reg <= 1'b1;
      ub_n_reg <= 1'b1;
      lb_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      addr_reg <= '0;
      dout_reg <= '0;
      rdata_reg <= '0;
      rsp_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      cs_n_reg <= cs_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      tok_n_reg <= tok_n_next;
      ub_n_reg <= ub_n_next;
      lb_n_reg <= lb_n_next;
      doe_reg <= doe_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      rdata_reg <= rdata_next;
      rsp_reg <= rsp_next;
    end
  end
  // Pin and user outputs
  assign req_ready = (state_reg == dprh_pkg::DPRH_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign chip_sel_n = cs_n_reg;
  assign rd_wr_n = we_n_reg;
  assign out_gate_n = oe_n_reg;
  assign token_latch_select_n = tok_n_reg;
  assign high_byte_lane_sel_n = ub_n_reg;
  assign low_byte_lane_sel_n = lb_n_reg;
  assign mem_addr = addr_reg;
  assign data_out = dout_reg;
  assign data_oe = doe_reg;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] gate_cnt_reg, gate_cnt_next;
  // Cycles that select and output gate have both been low
  always_comb begin
    gate_cnt_next = 8'h00;
    if (!oe_n_reg && !(cs_n_reg && tok_n_reg) && gate_cnt_reg != 8'hff) begin
      gate_cnt_next = gate_cnt_reg + 8'h01;
    end
  end
  // Gate counter register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      gate_cnt_reg <= 8'h00;
    end else begin
      gate_cnt_reg <= gate_cnt_next;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_write_close;
    data_oe && !chip_sel_n ##1 chip_sel_n && !data_oe;
  endsequence
  a_write_data_held: assert property (
    $rose(rd_wr_n) && !chip_sel_n |-> s_write_close
  ) else $error("write data or select released before direction edge");
  a_write_busy_stall: assert property (
    state_reg == dprh_pkg::DPRH_STROBE && is_wr && busy_s2_reg
      |=> !rd_wr_n
  ) else $error("write strobe ended during contention");
  a_write_setup: assert property (
    $fell(rd_wr_n) |-> $past(data_oe) && $stable(data_out)
  ) else $error("write strobe without prior data setup");
  a_read_wait: assert property (
    state_reg == dprh_pkg::DPRH_STROBE && !is_wr && cnt_reg == 8'h00
      |-> gate_cnt_reg >= dprh_pkg::READ_CYC
  ) else $error("read sampled before access and pass-through delay");
  a_read_gated: assert property (
    rsp_valid && !is_wr |-> $past(!out_gate_n && rd_wr_n && !data_oe)
  ) else $error("read completed without output gate");
  a_token_sel: assert property (
    !token_latch_select_n |-> chip_sel_n
  ) else $error("token select and chip select both low");
  a_token_recover: assert property (
    $rose(token_latch_select_n) |=> token_latch_select_n && out_gate_n
  ) else $error("token select reasserted without recovery");
endmodule

`default_nettype wire

// ==== dprh_pkg.sv ====
// Shared constants and types for the dual-port memory port host controller
`default_nettype none

package dprh_pkg;

  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int T_WRITE_NS = 45;    // Write strobe width
  localparam int T_ACCESS_NS = 55;   // Select/gate to data valid
  localparam int T_PASS_NS = 40;     // Port-to-port pass-through
  localparam int T_RECOVER_NS = 15;  // Deselect time between cycles
  localparam int SYNC_STAGES = 2;

  // Least times round up to whole cycles
  localparam logic [7:0] WRITE_CYC = 8'((T_WRITE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] READ_CYC =
    8'((T_ACCESS_NS * CLK_MHZ + 999) / 1000 +
       (T_PASS_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES);
  localparam logic [7:0] RECOVER_CYC =
    8'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // Request kinds and controller states
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_ARRAY_RD = 2'h0;
  localparam logic [1:0] KIND_ARRAY_WR = 2'h1;
  localparam logic [1:0] KIND_TOKEN_RD = 2'h2;
  localparam logic [1:0] KIND_TOKEN_WR = 2'h3;
  localparam int KIND_WR_BIT = 0;
  localparam int KIND_TOKEN_BIT = 1;

  // Token latch address width
  localparam int TOKEN_ADDR_W = 3;

  typedef enum logic [2:0] {
    DPRH_IDLE,
    DPRH_SETUP,
    DPRH_STROBE,
    DPRH_HOLD,
    DPRH_RECOVER
  } dprh_state_t;

endpackage

`default_nettype wire

// ==== dprh_mem_model.sv ====
// Behavioural model of the memory device port seen by the host controller
`default_nettype none

module dprh_mem_model #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
) (
  input wire logic chip_sel_n,
  input wire logic rd_wr_n,
  input wire logic out_gate_n,
  input wire logic token_latch_select_n,
  input wire logic high_byte_lane_sel_n,
  input wire logic low_byte_lane_sel_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  output var logic [DATA_W-1:0] data_in,
  output logic contention_n_in,
  output var logic mailbox_n_in,
  input wire logic peer_busy,
  input wire logic peer_post,
  input wire logic [7:0] peer_token
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Array, token latches and flags
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OWN_BOX = {{(ADDR_W-1){1'b1}}, 1'b0};
  // special_function_on held high, low words are plain memory
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] lane_m;
  logic [7:0] mine = 8'h00;
  logic rd_en;
  initial data_in = '0;
  initial mailbox_n_in = 1'b1;
  // byte lanes only exist on wide parts
  assign lane_m = (DATA_W == 8) ? '1 :
    DATA_W'({{8{~high_byte_lane_sel_n}}, {8{~low_byte_lane_sel_n}}});
  // port drives only while a read is enabled
  assign rd_en = !out_gate_n && rd_wr_n &&
    (chip_sel_n != token_latch_select_n);
  // busy follows the peer, as a secondary senses it
  assign contention_n_in = ~peer_busy;

  // data after access delay, owner read clears mail
  always @(posedge rd_en) begin
    #(dprh_pkg::T_ACCESS_NS);
    if (rd_en) begin
      data_in = !chip_sel_n ? mem[mem_addr] ^ ~lane_m :
        {DATA_W{!mine[mem_addr[2:0]]}};
      last = data_in;
      if (!chip_sel_n && mem_addr == OWN_BOX) mailbox_n_in = 1'b1;
    end
  end

  // Released bus shows the inverse, so stale data never passes
  always @(negedge rd_en) data_in = ~last;

  // write closes on the rising direction edge
  // latch granted only when the peer does not hold it
  always @(posedge rd_wr_n) begin
    if (!chip_sel_n) begin
      mem[mem_addr] = (mem[mem_addr] & ~lane_m) |
        ((data_oe ? data_out : ~data_out) & lane_m);
    end else if (!token_latch_select_n) begin
      mine[mem_addr[2:0]] = !data_out[0] && !peer_token[mem_addr[2:0]];
    end
  end

  // peer write to our mailbox raises the flag
  always @(posedge peer_post) mailbox_n_in = 1'b0;
endmodule

`default_nettype wire

// ==== dprh_port_ctrl_tb.sv ====
// Self-checking bench for the memory port host controller
`default_nettype none

module dprh_port_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Stimulus, instances and checking tasks
  // ------------------------------------------------------------
  localparam int AW = 14;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [1:0] req_byte_en = 2'h0;
  logic [AW-1:0] req_addr = '0;
  logic [15:0] req_wdata = 16'h0000;
  logic peer_busy = 1'b0;
  logic peer_post = 1'b0;
  logic [7:0] peer_token = 8'h00;
  logic req_ready, rsp_valid, mbox_pend, cont_seen, cs_n, rw_n, og_n;
  logic tok_n, hi_n, lo_n, oe, cont_n, mbox_n;
  logic [15:0] rsp_rdata, dout, din, rd;
  logic [AW-1:0] maddr;
  int err_total = 0;
  int compares = 0;
  always #20 sys_clk = ~sys_clk;

  dprh_port_ctrl #(.ADDR_W(AW), .DATA_W(16)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_byte_en(req_byte_en),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mailbox_pending(mbox_pend), .contention_seen(cont_seen),
    .chip_sel_n(cs_n), .rd_wr_n(rw_n), .out_gate_n(og_n),
    .token_latch_select_n(tok_n), .high_byte_lane_sel_n(hi_n),
    .low_byte_lane_sel_n(lo_n), .mem_addr(maddr), .data_out(dout),
    .data_oe(oe), .data_in(din), .contention_n_in(cont_n),
    .mailbox_n_in(mbox_n));
  dprh_mem_model #(.ADDR_W(AW), .DATA_W(16)) mem (
    .chip_sel_n(cs_n), .rd_wr_n(rw_n), .out_gate_n(og_n),
    .token_latch_select_n(tok_n), .high_byte_lane_sel_n(hi_n),
    .low_byte_lane_sel_n(lo_n), .mem_addr(maddr), .data_out(dout),
    .data_oe(oe), .data_in(din), .contention_n_in(cont_n),
    .mailbox_n_in(mbox_n), .peer_busy(peer_busy),
    .peer_post(peer_post), .peer_token(peer_token));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic end_sim;
    $display("errors %0d, compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Request held until taken, response awaited under a bound
  task automatic xfer(input logic [1:0] k, input logic [AW-1:0] a,
                      input logic [15:0] d, input logic [1:0] be,
                      input int bound, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    req_byte_en <= be;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 30) begin
      n++;
      @(negedge sys_clk);
    end
    if (req_ready !== 1'b1) begin
      $display("unexpected req_ready: expected 1, seen 0");
      err_total++;
      end_sim();
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && n <= bound) begin
      n++;
      @(negedge sys_clk);
      chk("select overlap", 16'h0001, 16'(cs_n | tok_n));
    end
    q = rsp_rdata;
    if (n > bound) begin
      $display("unexpected rsp_valid: expected 1, seen 0");
      err_total++;
      end_sim();
    end
  endtask

  task automatic t_reset;
    logic [15:0] pins;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    pins = {8'h00, cs_n, tok_n, og_n, rw_n, hi_n, lo_n, ~oe, req_ready};
    chk("idle pins", 16'h00ff, pins);
  endtask

  task automatic t_lanes;
    xfer(dprh_pkg::KIND_ARRAY_WR, 14'h0005, 16'h1234, 2'h3, 30, rd);
    xfer(dprh_pkg::KIND_ARRAY_WR, 14'h0005, 16'habcd, 2'h2, 30, rd);
    xfer(dprh_pkg::KIND_ARRAY_RD, 14'h0005, 16'h0000, 2'h3, 30, rd);
    chk("high lane write", 16'hab34, rd);
    xfer(dprh_pkg::KIND_ARRAY_WR, 14'h0005, 16'h00ef, 2'h1, 30, rd);
    xfer(dprh_pkg::KIND_ARRAY_RD, 14'h0005, 16'h0000, 2'h3, 30, rd);
    chk("low lane write", 16'habef, rd);
  endtask

  // Peer holds latch 5 only; each latch in turn is claimed (granted for all but 5), then freed before the next
  task automatic t_token;
    for (int i = 0; i < 8; i++) begin
      peer_token <= 8'h20;
      xfer(dprh_pkg::KIND_TOKEN_WR, AW'(i), 16'h0000, 2'h0, 30, rd);
      xfer(dprh_pkg::KIND_TOKEN_RD, AW'(i), 16'h0000, 2'h0, 30, rd);
      chk("token claim", (i == 5) ? 16'hffff : 16'h0000, rd);
      xfer(dprh_pkg::KIND_TOKEN_WR, AW'(i), 16'h0001, 2'h0, 30, rd);
      xfer(dprh_pkg::KIND_TOKEN_RD, AW'(i), 16'h0000, 2'h0, 30, rd);
      chk("token release", 16'hffff, rd);
    end
  endtask

  task automatic t_mail;
    @(posedge sys_clk);
    peer_post <= 1'b1;
    repeat (4) @(posedge sys_clk);
    peer_post <= 1'b0;
    @(negedge sys_clk);
    chk("mail raised", 16'h0001, 16'(mbox_pend));
    xfer(dprh_pkg::KIND_ARRAY_RD, 14'h3fff, 16'h0000, 2'h3, 30, rd);
    repeat (4) @(negedge sys_clk);
    chk("mail after peer box read", 16'h0001, 16'(mbox_pend));
    xfer(dprh_pkg::KIND_ARRAY_RD, 14'h3ffe, 16'h0000, 2'h3, 30, rd);
    repeat (4) @(negedge sys_clk);
    chk("mail after own read", 16'h0000, 16'(mbox_pend));
  endtask

  // Write under busy must stall, then land once busy drops
  task automatic t_busy;
    int n;
    n = 0;
    @(posedge sys_clk);
    peer_busy <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("busy seen", 16'h0001, 16'(cont_seen));
    fork
      xfer(dprh_pkg::KIND_ARRAY_WR, 14'h0009, 16'h5a5a, 2'h3, 60, rd);
      begin
        repeat (16) begin
          @(negedge sys_clk);
          if (rsp_valid !== 1'b0) n++;
        end
        peer_busy <= 1'b0;
      end
    join
    chk("write held by busy", 16'h0000, 16'(n));
    xfer(dprh_pkg::KIND_ARRAY_RD, 14'h0009, 16'h0000, 2'h3, 30, rd);
    chk("write after busy", 16'h5a5a, rd);
  endtask

  initial begin
    t_reset();
    t_lanes();
    t_token();
    t_mail();
    t_busy();
    end_sim();
  end
endmodule

`default_nettype wire
